/* File: verilog/ssr_map.svh */
// Constants of the status readback block of the pre-driver command port.
// Assumes inclusion by bare name from the top module.
// Function
// - fault byte replies every non-null command; null 00
// - null 01 returns mode byte, no change
// - null 10 returns mask byte, no change
// - null 11 returns deadtime byte, no change
// - fault byte layout; reset value 80h
// - flags stay latched; live cause never clears
// - clear commands share mask bit positions
// - bit 0 ORs three thermal detectors
// - bit 1 ORs drain faults, phase errors
// - phase error checked one deadtime after on
// - bit 4: comparator XOR drive, blanked
// - bit 5: bad frame length, calibration clocking
// - bit 6: locked write or undefined command
// - bit 7 set leaving reset
// - interrupt only from unmasked flags
// - mode bit 0 lock; locked writes ignored
// - mode bit 1 fullon; bits 7,2 zero
// - mode bit 3 set after deadtime command
// - mode bits 4,5,6: overflow, zero, drain mode
// - mask byte high/low halves, reset ones
// - deadtime byte reads zero before calibration
// - mask bit to fault bit mapping
// - active deadtime 255 after reset
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH
// Fault byte bit positions and reset value.
`define SSR_F_THERM 0
`define SSR_F_DRAIN 1
`define SSR_F_SUPPLY 2
`define SSR_F_OVERC 3
`define SSR_F_PHASE 4
`define SSR_F_FRAME 5
`define SSR_F_WERR 6
`define SSR_F_RESET 7
`define SSR_FAULT_RST 8'h80
// Mode byte bit positions.
`define SSR_M_LOCK 0
`define SSR_M_FULLON 1
`define SSR_M_DTCAL 3
`define SSR_M_OVF 4
`define SSR_M_ZERO 5
`define SSR_M_DRMODE 6
// Reset values of mask halves, stored and active deadtime.
`define SSR_MASK_RST 4'hf
`define SSR_DT_STORE_RST 8'h00
`define SSR_DT_MAX 8'hff
// Command byte fields.
`define SSR_OP_HI 7
`define SSR_OP_LO 5
`define SSR_HALF_BIT 4
`define SSR_CAL_BIT 0
`endif

/* File: verilog/ssr_pkg.sv */
// Types of the status readback block.
// Assumes ssr_map.svh sits beside it.
`default_nettype none
package ssr_pkg;
    // Frame tracker states, Gray coded along idle-frame-calibrate.
    typedef enum logic [1:0] {
        SSR_IDLE  = 2'b00,
        SSR_FRAME = 2'b01,
        SSR_CAL   = 2'b11
    } ssr_link_e;
    // Command opcodes in the top three bits of a command byte.
    typedef enum logic [2:0] {
        SSR_OP_NULL  = 3'h0,
        SSR_OP_MASK  = 3'h1,
        SSR_OP_MODE  = 3'h2,
        SSR_OP_CLEAR = 3'h3,
        SSR_OP_DEAD  = 3'h4
    } ssr_op_e;
    // Serial port pins.
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } ssr_spi_s;
    // Analog detector and comparator pins; thermal, drain and node sense have one bit per phase.
    typedef struct packed {
        logic [2:0] thermal_limit;
        logic [2:0] drain_voltage_fault;
        logic       supply_low;
        logic       overcurrent;
        logic [2:0] phase_node_sense;
    } ssr_sense_s;
endpackage
`default_nettype wire

/* File: verilog/ssr_top.sv */
// Status readback, fault latching and command port of the pre-driver.
// Assumes gate drive logic and deadtime calibration share i_clk.
`timescale 1ns/1ns
`default_nettype none
`include "ssr_map.svh"
module ssr_top (
    // Clock and reset.
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    // Serial port pins, asynchronous to i_clk.
    input  wire ssr_pkg::ssr_spi_s i_spi,
    output logic                   o_miso,
    output logic                   o_miso_oe,
    // Detector pins, asynchronous to i_clk.
    input  wire ssr_pkg::ssr_sense_s i_sense,
    // Gate drive state and blanking, same clock.
    input  wire logic [2:0]        i_hs_on,
    input  wire logic [2:0]        i_ls_on,
    input  wire logic              i_blank,
    // Calibration result, same clock.
    input  wire logic              i_cal_done,
    input  wire logic [7:0]        i_cal_count,
    input  wire logic              i_cal_ovf,
    // Settings and status toward the rest of the device.
    output logic                   o_irq,
    output logic [7:0]             o_mask,
    output logic                   o_lock,
    output logic                   o_fullon,
    output logic                   o_drain_mode,
    output logic [7:0]             o_deadtime,
    output logic                   o_cal_gate
);
    ////////////////////////////////////////////////////////////////////
    // Opcodes that software may not issue once locked.
    function automatic logic guarded(input logic [2:0] op);
        guarded = (op == ssr_pkg::SSR_OP_MASK) || (op == ssr_pkg::SSR_OP_MODE)
               || (op == ssr_pkg::SSR_OP_CLEAR) || (op == ssr_pkg::SSR_OP_DEAD);
    endfunction

    ssr_pkg::ssr_spi_s   spi_1, spi_2, spi_3;  // Pin synchroniser and edge stage.
    ssr_pkg::ssr_sense_s sen_1, sen_2;         // Detector synchroniser.
    ssr_pkg::ssr_link_e  st_q;                 // Frame tracker state.
    logic [7:0] rx_q;                          // Received byte.
    logic [2:0] bit_q;                         // Bits modulo eight.
    logic       got_q;                         // At least one bit seen.
    logic [7:0] tx_q;                          // Reply shifter.
    logic [1:0] sel_q;                         // Reply register select.
    logic       cal_arm_q;                     // Next frame is calibration.
    logic [7:0] fault_q;                       // Latched fault byte.
    logic [3:0] mask_lo_q, mask_hi_q;          // Interrupt mask halves.
    logic       lock_q, fullon_q, drmode_q;    // Mode settings.
    logic       dtcal_q, ovf_q, zero_q;        // Deadtime status.
    logic [7:0] dt_store_q, dt_act_q;          // Stored and active deadtime.
    logic       frame_err_q, werr_q;           // One-cycle error events.

    // Mode byte, assembled for readback.
    logic [7:0] mode_v;
    assign mode_v = {1'b0, drmode_q, zero_q, ovf_q, dtcal_q, 1'b0, fullon_q, lock_q};
    // Mask byte: high half above low half, bit for bit beside the faults.
    logic [7:0] mask_v;
    assign mask_v = {mask_hi_q, mask_lo_q};

    ////////////////////////////////////////////////////////////////////
    // Two flip-flops for every pin; the third stage only finds edges.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            spi_1 <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
            spi_2 <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
            spi_3 <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
            sen_1 <= '0;
            sen_2 <= '0;
        end else begin
            spi_1 <= i_spi;
            spi_2 <= spi_1;
            spi_3 <= spi_2;
            sen_1 <= i_sense;
            sen_2 <= sen_1;
        end
    end

    logic cs_fall, cs_rise, sck_rise, sck_fall;
    assign cs_fall  = spi_3.cs_n & ~spi_2.cs_n;
    assign cs_rise  = ~spi_3.cs_n & spi_2.cs_n;
    assign sck_rise = ~spi_3.sclk & spi_2.sclk;
    assign sck_fall = spi_3.sclk & ~spi_2.sclk;

    ////////////////////////////////////////////////////////////////////
    // Frame tracker; a frame after a calibrate command is only a pulse.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= ssr_pkg::SSR_IDLE;
        end else begin
            case (st_q)
                ssr_pkg::SSR_IDLE: begin
                    if (cs_fall) begin
                        st_q <= cal_arm_q ? ssr_pkg::SSR_CAL : ssr_pkg::SSR_FRAME;
                    end
                end
                ssr_pkg::SSR_FRAME, ssr_pkg::SSR_CAL: begin
                    if (cs_rise) begin
                        st_q <= ssr_pkg::SSR_IDLE;
                    end
                end
                default: st_q <= ssr_pkg::SSR_IDLE;
            endcase
        end
    end

    // Receive shifter and bit counter, sampled on rising serial clock.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_q  <= 8'h00;
            bit_q <= 3'h0;
            got_q <= 1'b0;
        end else if (cs_fall) begin
            bit_q <= 3'h0;
            got_q <= 1'b0;
        end else if (st_q == ssr_pkg::SSR_FRAME && sck_rise) begin
            rx_q  <= {rx_q[6:0], spi_2.mosi};
            bit_q <= bit_q + 3'h1;
            got_q <= 1'b1;
        end
    end

    // A whole frame ends with a command; the last byte is taken.
    logic       cmd_v;
    logic [2:0] op_v;
    assign cmd_v = (st_q == ssr_pkg::SSR_FRAME) && cs_rise && got_q && (bit_q == 3'h0);
    assign op_v  = rx_q[`SSR_OP_HI:`SSR_OP_LO];

    // Framing faults: a length that is not a nonzero multiple of eight bits, or any clocking during calibration.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            frame_err_q <= 1'b0;
        end else begin
            frame_err_q <= ((st_q == ssr_pkg::SSR_FRAME) && cs_rise && !(got_q && bit_q == 3'h0))
                        || ((st_q == ssr_pkg::SSR_CAL) && (sck_rise || sck_fall));
        end
    end

    // Write faults: a guarded command while locked, or an unknown code.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            werr_q <= 1'b0;
        end else begin
            werr_q <= cmd_v && ((lock_q && guarded(op_v)) || op_v > ssr_pkg::SSR_OP_DEAD);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Null commands pick the next reply; any other command picks faults.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sel_q <= 2'h0;
        end else if (cmd_v) begin
            sel_q <= (op_v == ssr_pkg::SSR_OP_NULL) ? rx_q[1:0] : 2'h0;
        end
    end

    // Reply selected for the coming frame.
    logic [7:0] reply_v;
    always_comb begin
        case (sel_q)
            2'h1:    reply_v = mode_v;
            2'h2:    reply_v = mask_v;
            2'h3:    reply_v = dt_store_q;
            default: reply_v = fault_q;
        endcase
    end

    // Capturing at frame start keeps the byte steady while it shifts out.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_q <= 8'h00;
        end else if (cs_fall) begin
            tx_q <= reply_v;
        end else if (st_q == ssr_pkg::SSR_FRAME && sck_fall) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // The reply line is driven only inside a command frame.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_miso_oe  <= 1'b0;
            o_cal_gate <= 1'b0;
        end else begin
            o_miso_oe  <= (st_q == ssr_pkg::SSR_FRAME);
            o_cal_gate <= (st_q == ssr_pkg::SSR_CAL);
        end
    end
    assign o_miso = tx_q[7];

    ////////////////////////////////////////////////////////////////////
    // Mask and mode writes; lock is sticky until reset.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mask_lo_q <= `SSR_MASK_RST;
            mask_hi_q <= `SSR_MASK_RST;
            lock_q    <= 1'b0;
            fullon_q  <= 1'b0;
            drmode_q  <= 1'b0;
        end else if (cmd_v && !lock_q) begin
            if (op_v == ssr_pkg::SSR_OP_MASK) begin
                if (rx_q[`SSR_HALF_BIT]) begin
                    mask_hi_q <= rx_q[3:0];
                end else begin
                    mask_lo_q <= rx_q[3:0];
                end
            end else if (op_v == ssr_pkg::SSR_OP_MODE) begin
                lock_q   <= rx_q[`SSR_M_LOCK];
                fullon_q <= rx_q[`SSR_M_FULLON];
                drmode_q <= rx_q[3];
            end
        end
    end

    // Deadtime commands and calibration results.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cal_arm_q  <= 1'b0;
            dtcal_q    <= 1'b0;
            ovf_q      <= 1'b0;
            zero_q     <= 1'b0;
            dt_store_q <= `SSR_DT_STORE_RST;
            dt_act_q   <= `SSR_DT_MAX;
        end else if (cmd_v && !lock_q && op_v == ssr_pkg::SSR_OP_DEAD) begin
            if (rx_q[`SSR_CAL_BIT]) begin
                cal_arm_q <= 1'b1;
            end else begin
                dtcal_q    <= 1'b1;
                zero_q     <= 1'b1;
                ovf_q      <= 1'b0;
                dt_store_q <= 8'h00;
                dt_act_q   <= 8'h00;
            end
        end else if (i_cal_done) begin
            dtcal_q    <= 1'b1;
            ovf_q      <= i_cal_ovf;
            zero_q     <= 1'b0;
            dt_store_q <= i_cal_count;
            dt_act_q   <= i_cal_ovf ? `SSR_DT_MAX : i_cal_count;
        end else if (st_q == ssr_pkg::SSR_CAL) begin
            cal_arm_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Per phase: check the node one deadtime after a side turns on.
    logic [2:0] ph_err, xor_err;
    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_phase
            logic       hs_q, ls_q, arm_q;
            logic [7:0] cnt_q;
            logic       node;
            assign node = sen_2.phase_node_sense[p];
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    hs_q  <= 1'b0;
                    ls_q  <= 1'b0;
                    arm_q <= 1'b0;
                    cnt_q <= 8'h00;
                end else begin
                    hs_q <= i_hs_on[p];
                    ls_q <= i_ls_on[p];
                    if ((i_hs_on[p] & ~hs_q) | (i_ls_on[p] & ~ls_q)) begin
                        arm_q <= 1'b1;
                        cnt_q <= dt_act_q;
                    end else if (arm_q && cnt_q != 8'h00) begin
                        cnt_q <= cnt_q - 8'h01;
                    end else begin
                        arm_q <= 1'b0;
                    end
                end
            end
            assign ph_err[p] = arm_q && cnt_q == 8'h00
                            && ((i_hs_on[p] && !node) || (i_ls_on[p] && node));
            assign xor_err[p] = (i_hs_on[p] ^ i_ls_on[p]) && (node ^ i_hs_on[p])
                             && !i_blank;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Causes of each flag and the clear vector of this cycle.
    logic [7:0] cause_v, clr_v;
    always_comb begin
        cause_v                = 8'h00;
        cause_v[`SSR_F_THERM]  = |sen_2.thermal_limit;
        cause_v[`SSR_F_DRAIN]  = |sen_2.drain_voltage_fault | (|ph_err);
        cause_v[`SSR_F_SUPPLY] = sen_2.supply_low;
        cause_v[`SSR_F_OVERC]  = sen_2.overcurrent;
        cause_v[`SSR_F_PHASE]  = |xor_err;
        cause_v[`SSR_F_FRAME]  = frame_err_q;
        cause_v[`SSR_F_WERR]   = werr_q;
        clr_v = 8'h00;
        if (cmd_v && !lock_q && op_v == ssr_pkg::SSR_OP_CLEAR) begin
            clr_v = rx_q[`SSR_HALF_BIT] ? {rx_q[3:0], 4'h0} : {4'h0, rx_q[3:0]};
        end
    end

    // Latched faults: a live cause beats a clear in the same cycle.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            fault_q <= `SSR_FAULT_RST;
        end else begin
            fault_q <= (fault_q & ~clr_v) | cause_v;
        end
    end

    // Interrupt and settings outputs.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(fault_q & mask_v);
        end
    end
    assign o_mask       = mask_v;
    assign o_lock       = lock_q;
    assign o_fullon     = fullon_q;
    assign o_drain_mode = drmode_q;
    assign o_deadtime   = dt_act_q;

    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_flag_sticky: assert property (((($past(fault_q) & ~fault_q) & ~$past(clr_v)) == 8'h00))
        else $error("fault flag dropped without clear");
    a_cause_wins: assert property (cause_v != 8'h00 |=> (fault_q & $past(cause_v)) == $past(cause_v))
        else $error("live cause not latched");
    a_irq_masked: assert property (1 |=> o_irq == $past(|(fault_q & mask_v)))
        else $error("interrupt does not follow masked flags");
    a_lock_ignores: assert property (cmd_v && lock_q && guarded(op_v) |=> $stable(mask_v) ##1 fault_q[6])
        else $error("locked write changed state or no write error");
    a_reply_capture: assert property (cs_fall |=> tx_q == $past(reply_v))
        else $error("reply not captured at frame start");
    a_thermal_or: assert property (|sen_2.thermal_limit |=> fault_q[0])
        else $error("thermal flag missing");
    a_frame_len: assert property (st_q == ssr_pkg::SSR_FRAME && cs_rise && bit_q != 3'h0 |=> ##1 fault_q[5])
        else $error("framing error not latched");
    a_null_quiet: assert property (cmd_v && op_v == ssr_pkg::SSR_OP_NULL |=> $stable(mode_v) && $stable(mask_v))
        else $error("null command changed state");
    a_zero_dead: assert property (cmd_v && !lock_q && op_v == ssr_pkg::SSR_OP_DEAD && !rx_q[0] |=> mode_v[3] && mode_v[5] && dt_act_q == 8'h00)
        else $error("zero deadtime not reported");

    c_null_mode: cover property (cmd_v && op_v == ssr_pkg::SSR_OP_NULL && rx_q[1:0] == 2'h1);
    c_clear_flag: cover property (clr_v != 8'h00 ##1 fault_q[7] == 1'b0);
    c_cal_frame: cover property (st_q == ssr_pkg::SSR_CAL ##1 i_cal_done);
endmodule
`default_nettype wire

/* File: verification/ssr_host_model.sv */
// Host serial master model that drives the status readback port.
// Assumes the device samples select, clock and data with its own clock.
`timescale 1ns/1ns
`default_nettype none
module ssr_host_model (
    // Strobe timing clock.
    input  wire logic             i_clk,
    // Serial pins.
    output var ssr_pkg::ssr_spi_s o_spi,
    input  wire logic             i_miso,
    // Reply byte of the last eight-bit frame.
    output var logic [7:0]        o_reply,
    output var logic              o_reply_v
);
    ////////////////////////////////////////////////////////////////////////////////
    // Idle: select high and clock low, so the link clock stands still outside frames.
    initial begin
        o_spi = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
        o_reply = 8'h00;
        o_reply_v = 1'b0;
    end
    // Shift the low nbits out MSB first; the reply bit is taken on each rising edge.
    task automatic xfer(input logic [15:0] data, input int nbits);
        logic [7:0] rx;
        rx = 8'h00;
        #1 o_spi.cs_n = 1'b0;
        #63;
        for (int i = nbits - 1; i >= 0; i--) begin
            o_spi.mosi = data[i];
            #62 o_spi.sclk = 1'b1;
            rx = {rx[6:0], i_miso};
            #63 o_spi.sclk = 1'b0;
        end
        #63 o_spi.cs_n = 1'b1;
        // Released data line shows the inverse, so a stale bit is never reused.
        o_spi.mosi = ~o_spi.mosi;
        if (nbits == 8) begin
            @(posedge i_clk) o_reply <= rx;
            o_reply_v <= 1'b1;
            @(posedge i_clk) o_reply_v <= 1'b0;
        end
        #63;
    endtask
    // A select pulse with no data, optionally with one stray clock pulse inside.
    task automatic pulse(input int len, input logic tog);
        #1 o_spi.cs_n = 1'b0;
        #(len / 2);
        o_spi.sclk = tog;
        #63 o_spi.sclk = 1'b0;
        #(len / 2) o_spi.cs_n = 1'b1;
        #63;
    endtask
endmodule
`default_nettype wire

/* File: verification/tb_spi_status_readback.sv */
// Self-checking bench of the status readback block.
// Assumes the host model beside it and the design package compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_spi_status_readback;
    // Design pins.
    logic                i_clk;
    logic                i_rst;
    ssr_pkg::ssr_spi_s   spi;
    ssr_pkg::ssr_sense_s sense;
    logic [2:0]          hs_on;
    logic [2:0]          ls_on;
    logic                blank;
    logic                cal_done;
    logic                cal_ovf;
    logic [7:0]          cal_count;
    logic                miso;
    logic                miso_oe;
    logic                cal_gate;
    logic                irq;
    logic                lock;
    logic                fullon;
    logic                drain_mode;
    logic [7:0]          mask;
    logic [7:0]          deadtime;
    logic [7:0]          reply;
    logic                reply_v;
    // Expected fault, mode, mask, stored and active deadtime, live causes, select.
    logic [7:0]          ef, em, ek, ed, ea, live;
    logic [1:0]          sel;
    logic [7:0]          expq[$];
    logic [31:0]         rng;
    int                  err_total;
    int                  checks;
    ////////////////////////////////////////////////////////////////////////////////
    ssr_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_spi(spi), .o_miso(miso), .o_miso_oe(miso_oe),
        .i_sense(sense), .i_hs_on(hs_on), .i_ls_on(ls_on), .i_blank(blank),
        .i_cal_done(cal_done), .i_cal_count(cal_count), .i_cal_ovf(cal_ovf), .o_irq(irq),
        .o_mask(mask), .o_lock(lock), .o_fullon(fullon), .o_drain_mode(drain_mode),
        .o_deadtime(deadtime), .o_cal_gate(cal_gate));
    ssr_host_model host (.i_clk(i_clk), .o_spi(spi), .i_miso(miso), .o_reply(reply),
        .o_reply_v(reply_v));
    // Free-running 125 MHz time base.
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nxt();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    // Register the previous command selected.
    function automatic logic [7:0] cur();
        return (sel == 2'd0) ? ef : (sel == 2'd1) ? em : (sel == 2'd2) ? ek : ed;
    endfunction
    task automatic cmp8(input string name, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic cmp_lvl(input string name, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %b seen %b", name, e, g);
        end
    endtask
    // Update the expectation as the device should act on a taken command.
    task automatic apply(input logic [7:0] c);
        sel = (c[7:5] == 3'h0) ? c[1:0] : 2'd0;
        if (c[7:5] > 3'h4 || (c[7:5] != 3'h0 && em[0]))
            ef[6] = 1'b1;
        else if (c[7:5] == 3'h1 && c[4])
            ek[7:4] = c[3:0];
        else if (c[7:5] == 3'h1)
            ek[3:0] = c[3:0];
        else if (c[7:5] == 3'h2)
            em = {1'b0, c[3], em[5:2], c[1], c[0]};
        else if (c[7:5] == 3'h3)
            ef = (ef & ~(c[4] ? {c[3:0], 4'h0} : {4'h0, c[3:0]})) | live;
        else if (c[7:5] == 3'h4 && !c[0]) begin
            ed = 8'h00;
            ea = 8'h00;
            em = (em | 8'h28) & ~8'h10;
        end
    endtask
    // One whole command frame; the reply it should carry is queued first.
    task automatic send(input logic [7:0] c);
        expq.push_back(cur());
        fork
            host.xfer({8'h00, c}, 8);
            begin
                #503;
                cmp_lvl("miso_oe", 1'b1, miso_oe);
            end
        join
        repeat (4) @(posedge i_clk);
        apply(c);
        cmp_lvl("irq", |(ef & ek), irq);
    endtask
    task automatic reset_all();
        i_rst <= 1'b1;
        {ef, em, ek, ed, ea, live, sel} = {8'h80, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 2'd0};
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (5) @(posedge i_clk);
    endtask
    // Raise or drop one detector: thermal, drain, supply, overcurrent.
    task automatic cause(input int k, input logic v);
        @(posedge i_clk);
        case (k)
            0: sense.thermal_limit[2] <= v;
            1: sense.drain_voltage_fault[1] <= v;
            2: sense.supply_low <= v;
            default: sense.overcurrent <= v;
        endcase
        repeat (8) @(posedge i_clk);
        live[k] = v;
        ef = ef | live;
    endtask
    task automatic calib(input logic ovf, input logic tog);
        logic [7:0] v;
        v = 8'(nxt());
        send(8'h81);
        fork
            host.pulse(2000, tog);
            begin
                #1003;
                cmp_lvl("cal_gate", 1'b1, cal_gate);
            end
        join
        @(posedge i_clk);
        cal_done <= 1'b1;
        cal_count <= v;
        cal_ovf <= ovf;
        @(posedge i_clk);
        cal_done <= 1'b0;
        repeat (4) @(posedge i_clk);
        {ed, ea, em[5:3]} = {v, ovf ? 8'hff : v, 1'b0, ovf, 1'b1};
        ef[5] = ef[5] | tog;
        cmp8("deadtime", ea, deadtime);
        send(8'h03);
        send(8'h01);
        send(8'h00);
    endtask
    task automatic finish_test();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Each whole reply is matched against the oldest queued expectation.
    always @(posedge i_clk) begin
        if (reply_v === 1'b1)
            cmp8("reply", expq.pop_front(), reply);
    end
    // A hang counts as a mismatch.
    initial begin
        #600000;
        err_total++;
        finish_test();
    end
    initial begin
        rng = 32'd65;
        err_total = 0;
        checks = 0;
        {i_rst, sense, hs_on, ls_on, blank, cal_done, cal_ovf, cal_count} = '0;
        reset_all();
        cmp8("deadtime", 8'hff, deadtime);
        for (int i = 0; i < 5; i++)
            send(8'(i % 4));
        send(8'h78);
        send(8'h00);
        for (int i = 0; i < 2; i++) begin
            rng = nxt();
            send({4'h2, rng[3:0]});
            send({4'h3, rng[7:4]});
            cmp8("mask", ek, mask);
            send(8'h02);
            send(8'h00);
        end
        send(8'h3f);
        for (int k = 0; k < 4; k++) begin
            send(8'h20);
            cause(k, 1'b1);
            send(8'h00);
            send(8'h2f);
            send(8'h60 | (8'h01 << k));
            cause(k, 1'b0);
            send(8'h60 | (8'h01 << k));
            send(8'h00);
        end
        // Node high before the high-side drive, then a glitch inside and outside blanking.
        sense.phase_node_sense[0] <= 1'b1;
        repeat (5) @(posedge i_clk);
        hs_on[0] <= 1'b1;
        repeat (300) @(posedge i_clk);
        {blank, sense.phase_node_sense[0]} <= 2'b10;
        repeat (5) @(posedge i_clk);
        sense.phase_node_sense[0] <= 1'b1;
        repeat (5) @(posedge i_clk);
        blank <= 1'b0;
        send(8'h00);
        sense.phase_node_sense[0] <= 1'b0;
        repeat (5) @(posedge i_clk);
        sense.phase_node_sense[0] <= 1'b1;
        ef[4] = 1'b1;
        repeat (5) @(posedge i_clk);
        hs_on[0] <= 1'b0;
        send(8'h00);
        send(8'h71);
        // Low side on with node still high after the deadtime, bit 4 blanked.
        {blank, ls_on[1], sense.phase_node_sense[1]} <= 3'b111;
        repeat (300) @(posedge i_clk);
        ls_on[1] <= 1'b0;
        repeat (5) @(posedge i_clk);
        {blank, sense.phase_node_sense[1]} <= 2'b00;
        ef[1] = 1'b1;
        send(8'h00);
        send(8'h62);
        host.xfer(16'h0000, 7);
        ef[5] = 1'b1;
        host.xfer(16'ha002, 16);
        apply(8'h02);
        send(8'h00);
        for (int o = 5; o < 8; o++)
            send({3'(o), 5'h00});
        send(8'h76);
        calib(1'b0, 1'b0);
        calib(1'b1, 1'b1);
        send(8'h4a);
        send(8'h4b);
        cmp_lvl("lock", 1'b1, lock);
        cmp_lvl("fullon", 1'b1, fullon);
        cmp_lvl("drain_mode", 1'b1, drain_mode);
        send(8'h20);
        send(8'h02);
        send(8'h01);
        send(8'h00);
        reset_all();
        send(8'h80);
        cmp8("deadtime", 8'h00, deadtime);
        send(8'h01);
        send(8'h03);
        send(8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
